// *** pkg/rps_map.svh ***
// Offsets, field positions, reset values and timing counts of the
// reset, prescaler and watchdog block. Definitions only.
`ifndef RPS_MAP_SVH
`define RPS_MAP_SVH
`define OFS_DIVCTL 8'h00
`define OFS_WDCTL 8'h04
`define OFS_MISC 8'h08
`define OFS_STATUS 8'h0C
`define DC_MASK_BIT 3
`define DC_CLR_BIT 2
`define WD_CLR_BIT 3
`define WD_SLMASK_BIT 2
`define MC_CLKOUT_BIT 0
`define MC_WDOG_DIS_BIT 1
`define MC_SOFTWARE_POWER_ON_RESET_START_BIT 2
`define ST_COLD_BIT 0
`define ST_PCOK_BIT 1
`define RST_SEL 2'h0
`define RST_SLMASK 1'h1
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define ACLK_HZ 10000000
`define SYS_CLK_HZ 32768
`define COLD_TICKS 16'h8000
`define PC_FIRST_TICK 16'h4000
`define TAP_1HZ 14
`define TAP_8HZ 11
`define TAP_32HZ 9
`define WD_LAST 2'h2
`define WD_HOLD_TICKS 2'h2
// Jump-to-zero encoding is arbitrary here; the core decodes it
`define JUMP0_OPCODE 16'h0000
`endif

// *** pkg/rps_pkg.sv ***
// Types shared by the reset, prescaler and watchdog block.
// Assumes rps_map.svh supplies the numeric constants.
`default_nettype none
package rps_pkg;
  typedef enum logic [0:0] {
    PWR_COLD = 1'b0,
    PWR_RUN = 1'b1
  } pwr_state_t;
  typedef enum logic [1:0] {
    IRQ_NONE = 2'b00,
    IRQ_1HZ = 2'b01,
    IRQ_8HZ = 2'b10,
    IRQ_32HZ = 2'b11
  } irq_sel_t;
endpackage : rps_pkg
`default_nettype wire

// *** core/reset_prescaler_watchdog.sv ***
// Reset sequencing, fifteen-stage prescaler and watchdog for the core.
// Assumes aclk at 10 MHz, an AXI4-Lite master on the same clock, and a
// supply comparator output arriving asynchronously.
//
// Contract
// (R01) Watchdog time-out reset only while watchdog disable bit is 0.
// (R02) Writing 1 to software POR bit starts full power-on reset.
// (R03) After software POR, stay in reset until power-check passes.
// (R04) Reset loads jump-zero, stack level zero, clears halt.
// (R05) Power-check holds cold reset until supply exceeds lowest threshold.
// (R06) First supply comparison after 16384 system clocks of cold start.
// (R07) Passing supply still waits for 32768-clock cold-start count.
// (R08) Failing supply rechecked every 8 Hz tick, reset held meanwhile.
// (R09) Clock-output bit drives 32.768 kHz system clock on strobe pin.
// (R10) Sleep stops the system clock; no derived clocks run.
// (R11) Prescaler is a fifteen-stage divider fed by the system clock.
// (R12) Select 00 none, 01 1 Hz, 10 8 Hz, 11 32 Hz interrupt.
// (R13) Control: mask bit 3, clear bit 2, select bits 1:0; reset 0.
// (R14) Watchdog not cleared within three seconds issues system reset.
// (R15) Watchdog keeps counting while the CPU is halted.
// (R16) Prescaler clear may shorten time-out to two seconds.
// (R17) Writing 1 to watchdog clear restarts it; 0 does nothing.
// (R18) Watchdog count bits 1:0 read-only, toggle 1/4, 1/2 Hz, reset 0.
// (R19) Software should clear watchdog from the 1 Hz interrupt.
// (R20) Strobe pin high while any system reset source is active.
// (R21) Watchdog disable bit reads 0 after reset.
// (R22) Prescaler clear write resets all divider stages.
// (R23) Watchdog clocked from 1 Hz tap, resets at three-second count.
//
// Design decisions made here: the AXI4-Lite slave port and the address map.
`default_nettype none
`include "rps_map.svh"
module reset_prescaler_watchdog import rps_pkg::*; #(
  parameter int SYS_DIV = `ACLK_HZ / `SYS_CLK_HZ,
  parameter bit POWER_CHECK = 1'b1
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Supervision
  input wire logic supply_above_threshold,
  input wire logic sleep_mode,
  // Reset and clock outputs
  output logic sys_reset,
  output logic reset_cold,
  output logic strobe_reset_pin,
  output logic [14:0] prescaler_taps,
  output logic prescaler_irq,
  output logic timer_irq_mask,
  output logic sleep_write_mask,
  // CPU state forced by reset
  output logic [15:0] instruction_register_init,
  output logic [1:0] stack_pointer_init,
  output logic halt_clear
);
  localparam int DIV_W = $clog2(SYS_DIV + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SYS_DIV - 1);
  localparam logic [DIV_W-1:0] DIV_HALF = DIV_W'(SYS_DIV / 2);

  // A tap's falling edge: all lower stages and itself are ones at tick
  function automatic logic tap_fall(input logic [14:0] cnt,
                                    input int k);
    logic [14:0] m;
    m = 15'((32'h0000_0002 << k) - 1);
    tap_fall = (cnt & m) == m;
  endfunction : tap_fall

  function automatic logic mapped(input logic [7:0] a);
    mapped = a == `OFS_DIVCTL || a == `OFS_WDCTL ||
             a == `OFS_MISC || a == `OFS_STATUS;
  endfunction : mapped

  logic [DIV_W-1:0] div_q;
  logic tick_q, sysclk_q;
  logic [14:0] pre_q;
  logic sup_m_q, sup_s_q;
  pwr_state_t pwr_q;
  logic [15:0] cold_q;
  logic pc_ok_q;
  logic [1:0] wd_q, hold_q;
  logic [1:0] sel_q;
  logic mask_q, slmask_q, clkout_q, wdog_dis_q;
  logic aw_q, w_q;
  logic [7:0] awa_q;
  logic [31:0] wd_data_q;
  logic [3:0] wst_q;
  logic wr_fire, wr_lo, soft_por, pre_clr, wd_clr;
  logic t1, t8, t32, wd_timeout, rst_any;

  // Slave side: write taken when both address and data are held
  assign wr_fire = aw_q && w_q && !bvalid;
  assign wr_lo = wr_fire && wst_q[0] && mapped(awa_q);
  assign soft_por = wr_lo && awa_q == `OFS_MISC &&
                    wd_data_q[`MC_SOFTWARE_POWER_ON_RESET_START_BIT];
  assign pre_clr = wr_lo && awa_q == `OFS_DIVCTL &&
                   wd_data_q[`DC_CLR_BIT];
  assign wd_clr = wr_lo && awa_q == `OFS_WDCTL &&
                  wd_data_q[`WD_CLR_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awa_q <= 8'h00;
      wd_data_q <= 32'h0000_0000;
      wst_q <= 4'h0;
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_q <= 1'b1;
        awa_q <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        w_q <= 1'b1;
        wd_data_q <= wdata;
        wst_q <= wstrb;
        wready <= 1'b0;
      end
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp <= mapped(awa_q) ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        aw_q <= 1'b0;
        w_q <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
      rdata <= 32'h0000_0000;
      case (araddr)
        `OFS_DIVCTL: begin
          rdata[`DC_MASK_BIT] <= mask_q;
          rdata[1:0] <= sel_q;
        end
        `OFS_WDCTL: begin
          rdata[`WD_SLMASK_BIT] <= slmask_q;
          rdata[1:0] <= wd_q; // [R18]
        end
        `OFS_MISC: begin
          rdata[`MC_CLKOUT_BIT] <= clkout_q;
          rdata[`MC_WDOG_DIS_BIT] <= wdog_dis_q;
        end
        `OFS_STATUS: begin
          rdata[`ST_COLD_BIT] <= pwr_q == PWR_COLD;
          rdata[`ST_PCOK_BIT] <= pc_ok_q;
        end
        default: rdata <= 32'h0000_0000;
      endcase
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // Software registers; a system reset returns them to their defaults
  always_ff @(posedge aclk) begin
    if (!aresetn || sys_reset) begin
      sel_q <= `RST_SEL; // [R13]
      mask_q <= 1'b0;
      slmask_q <= `RST_SLMASK;
      clkout_q <= 1'b0;
      wdog_dis_q <= 1'b0; // [R21]
    end else if (wr_lo) begin
      case (awa_q)
        `OFS_DIVCTL: begin
          mask_q <= wd_data_q[`DC_MASK_BIT]; // [R13]
          sel_q <= wd_data_q[1:0];
        end
        `OFS_WDCTL: slmask_q <= wd_data_q[`WD_SLMASK_BIT];
        `OFS_MISC: begin
          clkout_q <= wd_data_q[`MC_CLKOUT_BIT];
          wdog_dis_q <= wd_data_q[`MC_WDOG_DIS_BIT];
        end
        default: mask_q <= mask_q;
      endcase
    end
  end

  // System clock enable; stands still in sleep, so nothing derived runs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= '0;
      tick_q <= 1'b0;
      sysclk_q <= 1'b0;
    end else if (sleep_mode) begin
      tick_q <= 1'b0; // [R10]
      sysclk_q <= 1'b0;
    end else begin
      div_q <= div_q == DIV_LAST ? '0 : div_q + 1'b1;
      tick_q <= div_q == DIV_LAST;
      sysclk_q <= div_q < DIV_HALF;
    end
  end

  assign t1 = tick_q && tap_fall(pre_q, `TAP_1HZ);
  assign t8 = tick_q && tap_fall(pre_q, `TAP_8HZ);
  assign t32 = tick_q && tap_fall(pre_q, `TAP_32HZ);

  // Fifteen divider stages as one ripple count of system ticks
  always_ff @(posedge aclk) begin
    if (!aresetn || pre_clr) begin
      pre_q <= 15'h0000; // [R22]
    end else if (tick_q) begin
      pre_q <= pre_q + 15'h0001; // [R11]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prescaler_irq <= 1'b0;
    end else begin
      case (irq_sel_t'(sel_q)) // [R12]
        IRQ_1HZ: prescaler_irq <= t1;
        IRQ_8HZ: prescaler_irq <= t8;
        IRQ_32HZ: prescaler_irq <= t32;
        default: prescaler_irq <= 1'b0;
      endcase
    end
  end

  // Counts 1 Hz ticks whether or not the CPU is halted
  assign wd_timeout = !wdog_dis_q && t1 && wd_q == `WD_LAST; // [R01] [R14]
  always_ff @(posedge aclk) begin
    if (!aresetn || sys_reset || wd_clr || wdog_dis_q) begin
      wd_q <= 2'h0; // [R17]
    end else if (t1) begin
      wd_q <= wd_q + 2'h1; // [R15] [R23]
    end
  end

  // A prescaler clear moves the next 1 Hz tick, so the limit is 2..3 s
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_q <= 2'h0;
    end else if (wd_timeout) begin
      hold_q <= `WD_HOLD_TICKS; // [R16]
    end else if (tick_q && hold_q != 2'h0) begin
      hold_q <= hold_q - 2'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sup_m_q <= 1'b0;
      sup_s_q <= 1'b0;
    end else begin
      sup_m_q <= supply_above_threshold;
      sup_s_q <= sup_m_q;
    end
  end

  // Cold start: count oscillator ticks, then wait for a supply pass
  always_ff @(posedge aclk) begin
    if (!aresetn || soft_por) begin
      pwr_q <= PWR_COLD; // [R02] [R03]
      cold_q <= 16'h0000;
      pc_ok_q <= !POWER_CHECK;
    end else begin
      case (pwr_q)
        PWR_COLD: begin
          if (tick_q && cold_q != `COLD_TICKS) begin
            cold_q <= cold_q + 16'h0001;
          end
          if (tick_q && sup_s_q && (cold_q == `PC_FIRST_TICK ||
              (cold_q > `PC_FIRST_TICK && t8))) begin
            pc_ok_q <= 1'b1; // [R06] [R08]
          end
          if (cold_q == `COLD_TICKS && pc_ok_q) begin
            pwr_q <= PWR_RUN; // [R05] [R07]
          end
        end
        default: pwr_q <= PWR_RUN;
      endcase
    end
  end

  assign rst_any = pwr_q == PWR_COLD || hold_q != 2'h0 || wd_timeout;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sys_reset <= 1'b1;
      reset_cold <= 1'b1;
      strobe_reset_pin <= 1'b1;
      prescaler_taps <= 15'h0000;
      timer_irq_mask <= 1'b0;
      sleep_write_mask <= `RST_SLMASK;
    end else begin
      sys_reset <= rst_any;
      reset_cold <= pwr_q == PWR_COLD;
      // [R09] [R20]
      strobe_reset_pin <= clkout_q ? sysclk_q : rst_any;
      prescaler_taps <= pre_q;
      timer_irq_mask <= mask_q;
      sleep_write_mask <= slmask_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || rst_any) begin
      instruction_register_init <= `JUMP0_OPCODE; // [R04]
      stack_pointer_init <= 2'h0;
      halt_clear <= 1'b1;
    end else begin
      halt_clear <= 1'b0;
    end
  end

  property p_wd_off;
    @(posedge aclk) disable iff (!aresetn) wdog_dis_q |-> !wd_timeout;
  endproperty
  a_wd_off: assert property (p_wd_off) // [R01]
    else $error("watchdog fired while disabled");

  property p_soft_por;
    @(posedge aclk) disable iff (!aresetn)
      soft_por |=> pwr_q == PWR_COLD && cold_q == 16'h0000 ##1 sys_reset;
  endproperty
  a_soft_por: assert property (p_soft_por) // [R02]
    else $error("software reset did not restart cold start");

  property p_run_needs_pass;
    @(posedge aclk) disable iff (!aresetn)
      $rose(pwr_q == PWR_RUN) |-> $past(pc_ok_q) &&
        $past(cold_q) == `COLD_TICKS;
  endproperty
  a_run_needs_pass: assert property (p_run_needs_pass) // [R05]
    else $error("reset released early");

  property p_first_check;
    @(posedge aclk) disable iff (!aresetn)
      $rose(pc_ok_q) |-> $past(cold_q) >= `PC_FIRST_TICK;
  endproperty
  a_first_check: assert property (p_first_check) // [R06]
    else $error("supply compared before half cold start");

  property p_cpu_init;
    @(posedge aclk) disable iff (!aresetn)
      sys_reset |-> halt_clear && stack_pointer_init == 2'h0 &&
        instruction_register_init == `JUMP0_OPCODE;
  endproperty
  a_cpu_init: assert property (p_cpu_init) // [R04]
    else $error("cpu reset state not forced");

  property p_sleep_stops;
    @(posedge aclk) disable iff (!aresetn)
      sleep_mode [*3] |-> !tick_q && $stable(pre_q);
  endproperty
  a_sleep_stops: assert property (p_sleep_stops) // [R10]
    else $error("prescaler ran in sleep");

  property p_irq_sel;
    @(posedge aclk) disable iff (!aresetn)
      prescaler_irq |-> $past(sel_q) != 2'b00 &&
        ($past(sel_q) != 2'b01 || $past(pre_q) == 15'h7FFF);
  endproperty
  a_irq_sel: assert property (p_irq_sel) // [R12]
    else $error("prescaler interrupt with wrong select");

  property p_wd_clear;
    @(posedge aclk) disable iff (!aresetn) wd_clr |=> wd_q == 2'h0;
  endproperty
  a_wd_clear: assert property (p_wd_clear) // [R17]
    else $error("watchdog clear ignored");

  property p_strobe;
    @(posedge aclk) disable iff (!aresetn)
      !clkout_q |=> strobe_reset_pin == sys_reset;
  endproperty
  a_strobe: assert property (p_strobe) // [R20]
    else $error("strobe does not follow reset");

  property p_timeout;
    @(posedge aclk) disable iff (!aresetn)
      wd_timeout |=> sys_reset ##1 wd_q == 2'h0;
  endproperty
  a_timeout: assert property (p_timeout) // [R14]
    else $error("time-out gave no reset");

  c_run: cover property (@(posedge aclk) $rose(pwr_q == PWR_RUN));
  c_timeout: cover property (@(posedge aclk) wd_timeout);
  c_irq: cover property (@(posedge aclk) prescaler_irq);
  c_por: cover property (@(posedge aclk) soft_por);
endmodule : reset_prescaler_watchdog
`default_nettype wire

// *** bench/cpu_peer_model.sv ***
// Behavioural stand-in for the CPU core fed by the reset block.
// Assumes reset and its CPU-state outputs share aclk with the core.
`default_nettype none
`include "rps_map.svh"
module cpu_peer_model import rps_pkg::*; (
  // Clock and reset from the block
  input wire logic aclk,
  input wire logic sys_reset,
  // Forced state
  input wire logic [15:0] instruction_register_init,
  input wire logic [1:0] stack_pointer_init,
  // Observed core state
  output logic [11:0] program_counter_level0,
  output logic [1:0] stack_sel
);
  timeunit 1ns;
  timeprecision 1ns;
  // A wrong opcode parks the counter far from zero so the bench sees it
  always_ff @(posedge aclk) begin
    if (sys_reset) begin
      program_counter_level0 <=
        (instruction_register_init === `JUMP0_OPCODE) ?
        12'h000 : 12'hFFF;
      stack_sel <= stack_pointer_init;
    end else begin
      program_counter_level0 <= program_counter_level0 + 12'h001;
    end
  end
endmodule : cpu_peer_model
`default_nettype wire

// *** bench/reset_prescaler_watchdog_bench.sv ***
// Self-checking bench: cold start, prescaler, watchdog and soft reset.
// Assumes SYS_DIV=2, so one cold start lasts 65536 aclk cycles.
`default_nettype none
`include "rps_map.svh"
module reset_prescaler_watchdog_bench import rps_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic supply = 1'h0, sleep = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, sp_seen;
  logic [31:0] rdata;
  logic sys_reset, reset_cold, strobe, pirq, tmask, slmask, halt_clear;
  logic [14:0] taps;
  logic [15:0] ir_init;
  logic [1:0] sp_init;
  logic [11:0] pc;
  int failures = 0, checks = 0, cyc = 0;
  always #50 aclk = ~aclk;
  always @(posedge aclk) if (aresetn) cyc <= cyc + 1;
  reset_prescaler_watchdog #(.SYS_DIV(2), .POWER_CHECK(1'h1))
  u_reset_prescaler_watchdog (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .supply_above_threshold(supply), .sleep_mode(sleep),
    .sys_reset(sys_reset), .reset_cold(reset_cold),
    .strobe_reset_pin(strobe), .prescaler_taps(taps),
    .prescaler_irq(pirq), .timer_irq_mask(tmask),
    .sleep_write_mask(slmask), .instruction_register_init(ir_init),
    .stack_pointer_init(sp_init), .halt_clear(halt_clear));
  cpu_peer_model u_cpu_peer_model (
    .aclk(aclk), .sys_reset(sys_reset),
    .instruction_register_init(ir_init), .stack_pointer_init(sp_init),
    .program_counter_level0(pc), .stack_sel(sp_seen));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test();
    if (failures == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test
  task automatic hang();
    failures++;
    stop_test();
  endtask : hang
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    awaddr <= a; wdata <= d; wstrb <= 4'hF;
    awvalid <= 1'h1; wvalid <= 1'h1; bready <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid) break;
    end
    if (n == 50) hang();
    check({30'h0, bresp}, {30'h0, `RESP_OKAY});
    bready <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
    input logic [1:0] resp);
    int n;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'h1; rready <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid) break;
    end
    if (n == 50) hang();
    check(rdata, exp);
    check({30'h0, rresp}, {30'h0, resp});
    rready <= 1'h0;
  endtask : rd
  // Counts edges up to the next interrupt pulse; lim+1 means none came
  task automatic wait_irq(input int lim, output int n);
    for (n = 1; n <= lim; n++) begin
      @(posedge aclk);
      if (pirq) break;
    end
  endtask : wait_irq
  task automatic t_reset_state();
    check(sys_reset, 1'h1);
    check(strobe, 1'h1);
    check(ir_init, `JUMP0_OPCODE);
    check(sp_init, 2'h0);
    check(halt_clear, 1'h1);
    check(taps, 15'h0000);
  endtask : t_reset_state
  task automatic t_reg_defaults();
    rd(`OFS_DIVCTL, 32'h0000_0000, `RESP_OKAY);
    rd(`OFS_WDCTL, 32'h0000_0004, `RESP_OKAY);
    rd(`OFS_MISC, 32'h0000_0000, `RESP_OKAY);
    rd(`OFS_STATUS, 32'h0000_0001, `RESP_OKAY);
    rd(8'h10, 32'h0000_0000, `RESP_SLVERR);
  endtask : t_reg_defaults
  // Supply passes at the first check, half way into the count: release must still wait for 32768
  task automatic t_cold_start();
    int n;
    repeat (30000) @(posedge aclk);
    check(reset_cold, 1'h1);
    supply <= 1'h1;
    repeat (30000) @(posedge aclk);
    check(sys_reset, 1'h1);
    for (n = 0; n < 8000 && sys_reset; n++) @(posedge aclk);
    if (sys_reset) hang();
    check(cyc >= 65536 && cyc < 65600, 1'h1);
    check(pc, 12'h000);
    check(sp_seen, 2'h0);
    repeat (4) @(posedge aclk);
    check(reset_cold, 1'h0);
    check(halt_clear, 1'h0);
    rd(`OFS_STATUS, 32'h0000_0002, `RESP_OKAY);
  endtask : t_cold_start
  task automatic t_prescaler();
    int n;
    wr(`OFS_DIVCTL, 32'h0000_0007);
    wait_irq(2200, n);
    check(n > 2000 && n < 2100, 1'h1);
    wait_irq(2200, n);
    check(n, 2048);
    wr(`OFS_DIVCTL, 32'h0000_0006);
    wait_irq(8400, n);
    check(n > 8100 && n < 8250, 1'h1);
    wr(`OFS_DIVCTL, 32'h0000_0008);
    // The mask output is one register behind the control bit
    @(posedge aclk);
    check(tmask, 1'h1);
    rd(`OFS_DIVCTL, 32'h0000_0008, `RESP_OKAY);
    wait_irq(3000, n);
    check(n, 3001);
  endtask : t_prescaler
  task automatic t_sleep();
    logic [14:0] held;
    sleep <= 1'h1;
    repeat (3) @(posedge aclk);
    held = taps;
    repeat (50) @(posedge aclk);
    check(taps, held);
    sleep <= 1'h0;
    repeat (6) @(posedge aclk);
    check(taps != held, 1'h1);
  endtask : t_sleep
  task automatic t_clock_out();
    int highs;
    wr(`OFS_MISC, 32'h0000_0001);
    highs = 0;
    repeat (40) begin
      @(posedge aclk);
      highs += strobe;
    end
    check(highs, 20);
  endtask : t_clock_out
  task automatic t_watchdog_bits();
    wr(`OFS_DIVCTL, 32'h0000_0001);
    rd(`OFS_DIVCTL, 32'h0000_0001, `RESP_OKAY);
    // Clear as the 1 Hz handler would during a long standby
    wr(`OFS_WDCTL, 32'h0000_000C);
    rd(`OFS_WDCTL, 32'h0000_0004, `RESP_OKAY);
    check(slmask, 1'h1);
    wr(`OFS_WDCTL, 32'h0000_0003);
    rd(`OFS_WDCTL, 32'h0000_0000, `RESP_OKAY);
    wr(`OFS_MISC, 32'h0000_0002);
    rd(`OFS_MISC, 32'h0000_0002, `RESP_OKAY);
  endtask : t_watchdog_bits
  task automatic t_soft_por();
    int n;
    wr(`OFS_MISC, 32'h0000_0004);
    for (n = 0; n < 20 && !sys_reset; n++) @(posedge aclk);
    check(sys_reset, 1'h1);
    if (!sys_reset) hang();
    repeat (2) @(posedge aclk);
    check(strobe, 1'h1);
    check(reset_cold, 1'h1);
    rd(`OFS_MISC, 32'h0000_0000, `RESP_OKAY);
    rd(`OFS_STATUS, 32'h0000_0001, `RESP_OKAY);
  endtask : t_soft_por
  initial begin
    repeat (4) @(posedge aclk);
    t_reset_state();
    aresetn <= 1'h1;
    t_reg_defaults();
    t_cold_start();
    t_prescaler();
    t_sleep();
    t_clock_out();
    t_watchdog_bits();
    t_soft_por();
    stop_test();
  end
endmodule : reset_prescaler_watchdog_bench
`default_nettype wire
